// ---- rtl/dsr_cfg.svh ----
// Offsets, field positions, reset values and masks of the diagnostic status registers
`ifndef DSR_CFG_SVH
`define DSR_CFG_SVH

`define DSR_ADDR_W 5
`define DSR_WORD_W 22
`define DSR_WDATA_W 16
`define DSR_ADDR_ANALOG 5'h15
`define DSR_ADDR_STATUS 5'h16
`define DSR_RST_ANALOG 22'h150000
`define DSR_RST_STATUS 22'h160000

`define DSR_FAULT_BIT 21
`define DSR_ADDR_HI 20
`define DSR_ADDR_LO 16

`define DSR_BIT_CURRENT_OPEN 7
`define DSR_BIT_VOLTAGE_SHORT 6
`define DSR_BIT_DIE_TEMP 4
`define DSR_BIT_REF_OUTPUT 3
`define DSR_BIT_REF_INPUT 2
`define DSR_BIT_INT_SUPPLY 1
`define DSR_BIT_REGULATOR 0
`define DSR_NUM_FLAGS 7

`define DSR_SUMMARY_BIT 20
`define DSR_WDT_BIT 18
`define DSR_BUSY_BIT 17
`define DSR_TAG_HI 16
`define DSR_TAG_LO 12
`define DSR_DATA_HI 11
`define DSR_DATA_LO 0
`define DSR_TAG_W 5
`define DSR_DATA_W 12

// Logic flag positions: 0 serial CRC, 1 frame slip, 2 clock count, 13 reset occurred, 14 slew busy
`define DSR_RESET_OCCURRED_BIT 13
`define DSR_SUMMARY_MASK 16'hBFFF
`define DSR_QUIET_MASK 16'hBFF8
`define DSR_RST_SUMMARY 1'h1

`endif

// ---- rtl/dsr_pkg.sv ----
// Types shared by the diagnostic status register bank
`include "dsr_cfg.svh"

package dsr_pkg;

    typedef enum logic [2:0] {
        DSR_SEL_NONE   = 3'b001,
        DSR_SEL_ANALOG = 3'b010,
        DSR_SEL_STATUS = 3'b100
    } dsr_sel_t;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic flag;
    } dsr_cell_state_t;

    typedef struct packed {
        logic [`DSR_WORD_W-1:0] rd_data;
        logic rd_valid;
        logic ro_write;
        logic bad_access;
        logic fault_sync1;
        logic fault_sync2;
        logic summary;
        logic watchdog;
        logic busy;
        logic [`DSR_TAG_W-1:0] tag;
        logic [`DSR_DATA_W-1:0] data;
        logic any_fault;
    } dsr_state_t;

endpackage

// ---- rtl/dsr_flag_cell.sv ----
// One sticky write-one-to-clear analog fault flag with its detector synchroniser
`timescale 1ns/1ps
`include "dsr_cfg.svh"

module dsr_flag_cell
    import dsr_pkg::*;
(
    input wire logic clk,              // System clock
    input wire logic reset,            // Synchronous reset, active high
    input wire logic [1:0] cond_async, // Detector conditions, either one sets the flag
    input wire logic feature_enable,   // Diagnostic feature enabled
    input wire logic clear,            // Write of a one to this flag
    output logic flag_read             // Flag as software sees it
);

    dsr_cell_state_t state;
    dsr_cell_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.sync1 = cond_async;
        next_state.sync2 = state.sync1;
        // A detector hit in the clearing cycle keeps the flag set
        if (feature_enable && (state.sync2 != 2'h0)) begin
            next_state.flag = 1'h1;
        end else if (clear) begin
            next_state.flag = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // Disabled features read as zero whatever the detector says
    assign flag_read = state.flag & feature_enable;

endmodule

// ---- rtl/dsr_regs.sv ----
// Analog fault flag register and summary status register of the output converter
//
// Notes on behaviour
// - Analog fault flags are sticky; writing one clears a flag, zeros are ignored.
// - A flag whose diagnostic feature is disabled always reads as zero.
// - Bit 21 shows the fault pin in both registers; bits 20:16 echo the address in the analog register only.
// - Bit 7 sets on current output open or on too little driver headroom.
// - Bit 6 sets on a voltage output short circuit.
// - Bit 4 sets when the die is too hot.
// - Bit 3 sets when the reference output leaves its window or hits current limit.
// - Bit 2 sets when the reference input leaves its window.
// - Bit 1 sets when the internal analog supply leaves its window.
// - Bit 0 sets when the regulator leaves its window or hits current limit.
// - Status bit 20 is the OR of logic flags 15:0 without the slew-busy bit.
// - The summary bit reads one after power-up.
// - Quiet mode ORs only logic flags 15:3, still without the slew-busy bit.
// - Status bit 18 shows the watchdog; bit 17 shows the monitor converter busy.
// - Status bits 16:12 hold the channel tag of the presented result.
// - Status bits 11:0 hold the twelve-bit result of that channel.
// - Logic flags 0, 1 and 2 are CRC, frame slip and clock count errors.
// - Logic flag 13 marks a reset and is set at power-up.
`timescale 1ns/1ps
`include "dsr_cfg.svh"

module dsr_regs
    import dsr_pkg::*;
(
    input wire logic clk,                                     // System clock, 25 MHz
    input wire logic reset,                                   // Synchronous reset, active high
    // Register access from the serial decoder
    input wire logic reg_rd,                                  // Read strobe, one cycle
    input wire logic reg_wr,                                  // Write strobe, one cycle
    input wire logic [`DSR_ADDR_W-1:0] reg_addr,              // Register address
    input wire logic [`DSR_WDATA_W-1:0] reg_wdata,            // Write data field
    output logic [`DSR_WORD_W-1:0] rd_data,                   // Readback word
    output logic rd_valid,                                    // Readback word valid, one cycle
    output logic ro_write_attempt,                            // Write to the read-only status word
    output logic bad_address_access,                          // Access to an address not held here
    // Pin level
    input wire logic fault_pin,                               // Fault output pin level
    // Analog detectors, asynchronous levels
    input wire logic current_open,                            // Current output open circuit
    input wire logic current_headroom_low,                    // Current driver lacks headroom
    input wire logic voltage_short,                           // Voltage output short circuit
    input wire logic die_hot,                                 // Die temperature comparator
    input wire logic ref_output_window,                       // Reference output out of window
    input wire logic ref_output_limit,                        // Reference output current limit
    input wire logic ref_input_window,                        // Reference input out of window
    input wire logic supply_window,                           // Internal supply out of window
    input wire logic regulator_window,                        // Regulator out of window
    input wire logic regulator_limit,                         // Regulator current limit
    // Diagnostic feature enables
    input wire logic open_detect_en,                          // Open circuit detection on
    input wire logic short_detect_en,                         // Short circuit detection on
    input wire logic temp_detect_en,                          // Temperature detection on
    input wire logic ref_output_detect_en,                    // Reference output check on
    input wire logic ref_input_detect_en,                     // Reference input check on
    input wire logic supply_detect_en,                        // Internal supply check on
    input wire logic regulator_detect_en,                     // Regulator check on
    // Digital diagnostics, watchdog and monitor converter
    input wire logic [`DSR_WDATA_W-1:0] logic_fault_flags,    // Digital diagnostic flags
    input wire logic quiet_summary_enable,                    // Leave serial errors out of summary
    input wire logic watchdog_state,                          // Watchdog status
    input wire logic monitor_busy,                            // Monitor converter busy
    input wire logic monitor_result_valid,                    // New monitor result, one cycle
    input wire logic [`DSR_TAG_W-1:0] monitor_channel_tag,    // Channel of the new result
    input wire logic [`DSR_DATA_W-1:0] monitor_result,        // New result
    output logic analog_fault_any                             // Any analog flag set
);

    dsr_state_t state;
    dsr_state_t next_state;

    logic [`DSR_NUM_FLAGS-1:0] flag_read;
    logic [`DSR_NUM_FLAGS-1:0] flag_clear;
    logic [`DSR_NUM_FLAGS-1:0] flag_enable;
    logic [1:0] flag_cond [`DSR_NUM_FLAGS];
    dsr_sel_t sel;
    logic write_analog;

    // Address decode
    function automatic dsr_sel_t decode_addr(input logic [`DSR_ADDR_W-1:0] addr);
        dsr_sel_t result;
        case (addr)
            `DSR_ADDR_ANALOG: begin
                result = DSR_SEL_ANALOG;
            end
            `DSR_ADDR_STATUS: begin
                result = DSR_SEL_STATUS;
            end
            default: begin
                result = DSR_SEL_NONE;
            end
        endcase
        return result;
    endfunction

    // Fault pin and address header; the status word keeps only its fault pin bit
    function automatic logic [`DSR_WORD_W-1:0] header(input logic pin, input logic [`DSR_ADDR_W-1:0] addr);
        logic [`DSR_WORD_W-1:0] word;
        word = '0;
        word[`DSR_FAULT_BIT] = pin;
        word[`DSR_ADDR_HI:`DSR_ADDR_LO] = addr;
        return word;
    endfunction

    // Flag index to bit position; index order is regulator, supply, ref in, ref out, temp, short, open
    function automatic logic [`DSR_WDATA_W-1:0] place_flags(input logic [`DSR_NUM_FLAGS-1:0] f);
        logic [`DSR_WDATA_W-1:0] word;
        word = '0;
        word[`DSR_BIT_REGULATOR] = f[0];
        word[`DSR_BIT_INT_SUPPLY] = f[1];
        word[`DSR_BIT_REF_INPUT] = f[2];
        word[`DSR_BIT_REF_OUTPUT] = f[3];
        word[`DSR_BIT_DIE_TEMP] = f[4];
        word[`DSR_BIT_VOLTAGE_SHORT] = f[5];
        word[`DSR_BIT_CURRENT_OPEN] = f[6];
        return word;
    endfunction

    function automatic logic [`DSR_NUM_FLAGS-1:0] pick_flags(input logic [`DSR_WDATA_W-1:0] w);
        logic [`DSR_NUM_FLAGS-1:0] f;
        f[0] = w[`DSR_BIT_REGULATOR];
        f[1] = w[`DSR_BIT_INT_SUPPLY];
        f[2] = w[`DSR_BIT_REF_INPUT];
        f[3] = w[`DSR_BIT_REF_OUTPUT];
        f[4] = w[`DSR_BIT_DIE_TEMP];
        f[5] = w[`DSR_BIT_VOLTAGE_SHORT];
        f[6] = w[`DSR_BIT_CURRENT_OPEN];
        return f;
    endfunction

    // Summary of the digital flags; slew busy never counts, quiet mode drops serial errors
    function automatic logic summary_or(input logic [`DSR_WDATA_W-1:0] flags, input logic quiet);
        logic [`DSR_WDATA_W-1:0] mask;
        mask = quiet ? `DSR_QUIET_MASK : `DSR_SUMMARY_MASK;
        return |(flags & mask);
    endfunction

    assign sel = decode_addr(reg_addr);
    assign write_analog = reg_wr && (sel == DSR_SEL_ANALOG);
    // Only defined flag positions clear; reserved bits of the write are dropped
    assign flag_clear = write_analog ? pick_flags(reg_wdata) : '0;

    // Detector conditions, two per flag, the second tied low where one source exists
    assign flag_cond[0] = {regulator_limit, regulator_window};
    assign flag_cond[1] = {1'h0, supply_window};
    assign flag_cond[2] = {1'h0, ref_input_window};
    assign flag_cond[3] = {ref_output_limit, ref_output_window};
    assign flag_cond[4] = {1'h0, die_hot};
    assign flag_cond[5] = {1'h0, voltage_short};
    assign flag_cond[6] = {current_headroom_low, current_open};

    assign flag_enable = {open_detect_en, short_detect_en, temp_detect_en, ref_output_detect_en,
                          ref_input_detect_en, supply_detect_en, regulator_detect_en};

    for (genvar k = 0; k < `DSR_NUM_FLAGS; k++) begin : g_flag
        dsr_flag_cell u_cell (
            .clk(clk),
            .reset(reset),
            .cond_async(flag_cond[k]),
            .feature_enable(flag_enable[k]),
            .clear(flag_clear[k]),
            .flag_read(flag_read[k])
        );
    end

    always_comb begin
        next_state = state;
        next_state.rd_valid = 1'h0;
        next_state.ro_write = 1'h0;
        next_state.bad_access = 1'h0;

        // Fault pin crosses into the clock domain through two stages
        next_state.fault_sync1 = fault_pin;
        next_state.fault_sync2 = state.fault_sync1;

        next_state.summary = summary_or(logic_fault_flags, quiet_summary_enable);
        next_state.watchdog = watchdog_state;
        next_state.busy = monitor_busy;
        next_state.any_fault = |flag_read;

        // Tag and result are taken together so a read never mixes two conversions
        if (monitor_result_valid) begin
            next_state.tag = monitor_channel_tag;
            next_state.data = monitor_result;
        end

        if (reg_rd) begin
            next_state.rd_valid = 1'h1;
            case (sel)
                DSR_SEL_ANALOG: begin
                    next_state.rd_data = header(state.fault_sync2, `DSR_ADDR_ANALOG) |
                                         {6'h00, place_flags(flag_read)};
                end
                DSR_SEL_STATUS: begin
                    next_state.rd_data = header(state.fault_sync2, `DSR_ADDR_STATUS);
                    next_state.rd_data[`DSR_ADDR_HI:`DSR_ADDR_LO] = '0;
                    next_state.rd_data[`DSR_SUMMARY_BIT] = state.summary;
                    next_state.rd_data[`DSR_WDT_BIT] = state.watchdog;
                    next_state.rd_data[`DSR_BUSY_BIT] = state.busy;
                    next_state.rd_data[`DSR_TAG_HI:`DSR_TAG_LO] = state.tag;
                    next_state.rd_data[`DSR_DATA_HI:`DSR_DATA_LO] = state.data;
                end
                default: begin
                    next_state.rd_data = '0;
                    next_state.bad_access = 1'h1;
                end
            endcase
        end

        if (reg_wr) begin
            case (sel)
                DSR_SEL_ANALOG: begin
                    next_state.ro_write = 1'h0;
                end
                DSR_SEL_STATUS: begin
                    next_state.ro_write = 1'h1;
                end
                default: begin
                    next_state.bad_access = 1'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= '0;
            state.rd_data <= `DSR_RST_STATUS;
            // The reset-occurred logic flag is set at power-up, so the summary starts high
            state.summary <= `DSR_RST_SUMMARY;
        end else begin
            state <= next_state;
        end
    end

    assign rd_data = state.rd_data;
    assign rd_valid = state.rd_valid;
    assign ro_write_attempt = state.ro_write;
    assign bad_address_access = state.bad_access;
    assign analog_fault_any = state.any_fault;

endmodule

// ---- tb/dsr_host.sv ----
// Host model that reads and clears the diagnostic registers
`timescale 1ns/1ps
`include "dsr_cfg.svh"
module dsr_host
    import dsr_pkg::*;
(
    input wire logic clk, // Clock
    output logic reg_rd, // Read strobe
    output logic reg_wr, // Write strobe
    output logic [`DSR_ADDR_W-1:0] reg_addr, // Address
    output logic [`DSR_WDATA_W-1:0] reg_wdata, // Write data
    input wire logic [`DSR_WORD_W-1:0] rd_data, // Read word
    input wire logic rd_valid // Read word valid
);
    initial begin
        reg_rd = 1'b0;
        reg_wr = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
    end
    // Address, and on writes the data too, go to their inverse once released
    task automatic rd(input logic [4:0] a, output logic [21:0] d);
        @(negedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(negedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        d = (rd_valid === 1'b1) ? rd_data : 22'hXXXXXX;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] w);
        @(negedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(negedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~w;
    endtask
endmodule

// ---- tb/dsr_checker.sv ----
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`include "dsr_cfg.svh"
module dsr_chk
    import dsr_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset, // Reset
    input wire logic reg_rd, // Read strobe
    input wire logic [`DSR_ADDR_W-1:0] reg_addr, // Address
    input wire logic [`DSR_WORD_W-1:0] rd_data, // Read word
    input wire logic rd_valid, // Read valid
    input wire logic fault_pin, // Fault pin
    input wire logic open_detect_en, // Open detect enable
    input wire logic [`DSR_WDATA_W-1:0] logic_fault_flags, // Logic flags
    input wire logic quiet_summary_enable, // Quiet mode
    input wire logic watchdog_state, // Watchdog
    input wire logic monitor_busy, // Monitor busy
    input wire logic monitor_result_valid, // Monitor valid
    input wire logic [`DSR_TAG_W-1:0] monitor_channel_tag, // Monitor tag
    input wire logic [`DSR_DATA_W-1:0] monitor_result // Monitor result
);
    logic last_rd;
    logic [`DSR_ADDR_W-1:0] last_addr;
    wire logic an_rd = rd_valid && last_rd && last_addr == `DSR_ADDR_ANALOG;
    wire logic st_rd = rd_valid && last_rd && last_addr == `DSR_ADDR_STATUS;
    always_ff @(posedge clk) begin
        last_rd <= reg_rd;
        last_addr <= reg_addr;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_read_answer: assert property (reg_rd |=> rd_valid)
        else $error("read not answered");
    a_pin_level: assert property (rd_valid |-> rd_data[21] == $past(fault_pin, 3))
        else $error("fault pin bit wrong");
    a_analog_addr: assert property (an_rd |-> rd_data[20:8] == 13'h1500 && !rd_data[5])
        else $error("analog word fixed fields wrong");
    a_open_off: assert property (an_rd && !$past(open_detect_en) && !$past(open_detect_en, 2)
        |-> !rd_data[7])
        else $error("disabled flag reads one");
    a_summary_or: assert property (st_rd |-> rd_data[20] == |($past(logic_fault_flags, 2) &
        ($past(quiet_summary_enable, 2) ? `DSR_QUIET_MASK : `DSR_SUMMARY_MASK)))
        else $error("summary bit wrong");
    a_bit19_zero: assert property (st_rd |-> !rd_data[19])
        else $error("status bit 19 set");
    a_wdt_busy: assert property (st_rd |->
        rd_data[18:17] == {$past(watchdog_state, 2), $past(monitor_busy, 2)})
        else $error("watchdog or busy bit wrong");
    a_tag_data: assert property (monitor_result_valid ##1 !monitor_result_valid ##1
        (reg_rd && reg_addr == `DSR_ADDR_STATUS && !monitor_result_valid) |=>
        rd_data[16:0] == {$past(monitor_channel_tag, 3), $past(monitor_result, 3)})
        else $error("monitor tag or data wrong");
endmodule
bind dsr_regs dsr_chk u_chk (.clk, .reset, .reg_rd, .reg_addr, .rd_data, .rd_valid, .fault_pin, .open_detect_en,
    .logic_fault_flags, .quiet_summary_enable, .watchdog_state, .monitor_busy, .monitor_result_valid,
    .monitor_channel_tag, .monitor_result);

// ---- tb/testbench.sv ----
// Self-checking bench for the diagnostic status register bank
`timescale 1ns/1ps
`include "dsr_cfg.svh"
module testbench
    import dsr_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic fault_pin = 1'b0;
    logic [9:0] det = 10'h000;
    logic [6:0] en = 7'h7F;
    logic [15:0] lff = 16'h2000;
    logic quiet = 1'b0;
    logic wdt = 1'b0;
    logic busy = 1'b0;
    logic mval = 1'b0;
    logic [4:0] mtag = 5'h00;
    logic [11:0] mres = 12'h000;
    wire logic reg_rd, reg_wr, rd_valid, ro_w, bad, afa;
    wire logic [4:0] reg_addr;
    wire logic [15:0] reg_wdata;
    wire logic [21:0] rd_data;
    logic [21:0] d;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Detector rows: input index i sets analog flag fbit[i]
    int fbit[10] = '{7, 7, 6, 4, 3, 3, 2, 1, 0, 0};
    // Summary rows: flags, quiet mode, expected summary
    logic [15:0] lfv[7] = '{16'h0001, 16'h0001, 16'h4000, 16'h0004, 16'h0008, 16'h8000, 16'h2000};
    logic [6:0] qv = 7'b1111010;
    logic [6:0] sv = 7'b1110001;
    dsr_regs u_dut (.clk, .reset, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .rd_data, .rd_valid,
        .ro_write_attempt(ro_w), .bad_address_access(bad), .fault_pin, .current_open(det[0]),
        .current_headroom_low(det[1]), .voltage_short(det[2]), .die_hot(det[3]), .ref_output_window(det[4]),
        .ref_output_limit(det[5]), .ref_input_window(det[6]), .supply_window(det[7]),
        .regulator_window(det[8]), .regulator_limit(det[9]), .open_detect_en(en[0]), .short_detect_en(en[1]),
        .temp_detect_en(en[2]), .ref_output_detect_en(en[3]), .ref_input_detect_en(en[4]),
        .supply_detect_en(en[5]), .regulator_detect_en(en[6]), .logic_fault_flags(lff),
        .quiet_summary_enable(quiet), .watchdog_state(wdt), .monitor_busy(busy), .monitor_result_valid(mval),
        .monitor_channel_tag(mtag), .monitor_result(mres), .analog_fault_any(afa));
    dsr_host u_host (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .rd_data, .rd_valid);
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            report_and_stop();
        end
    end
    task report_and_stop();
        if (fails == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [21:0] e, input logic [21:0] s);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic rchk(input logic [4:0] a, input logic [21:0] e);
        u_host.rd(a, d);
        chk("rd_data", e, d);
    endtask
    function automatic logic [21:0] aw(input logic [7:0] f);
        return {fault_pin, `DSR_ADDR_ANALOG, 8'h00, f};
    endfunction
    initial begin
        repeat (16) @(negedge clk);
        chk("rd_data", `DSR_RST_STATUS, rd_data);
        chk("rd_valid", 22'h0, {21'h0, rd_valid});
        reset = 1'b0;
        rchk(`DSR_ADDR_STATUS, {1'b0, 1'b1, 20'h0});
        rchk(`DSR_ADDR_ANALOG, `DSR_RST_ANALOG);
        for (int i = 0; i < 10; i++) begin
            det[i] = 1'b1;
            repeat (4) @(negedge clk);
            det[i] = 1'b0;
            repeat (4) @(negedge clk);
            rchk(`DSR_ADDR_ANALOG, aw(8'h01 << fbit[i]));
            chk("analog_fault_any", 22'h1, {21'h0, afa});
            u_host.wr(`DSR_ADDR_ANALOG, ~(16'h0001 << fbit[i]));
            rchk(`DSR_ADDR_ANALOG, aw(8'h01 << fbit[i]));
            u_host.wr(`DSR_ADDR_ANALOG, 16'h0001 << fbit[i]);
            rchk(`DSR_ADDR_ANALOG, aw(8'h00));
            chk("analog_fault_any", 22'h0, {21'h0, afa});
        end
        // A clear while the detector still fires leaves the flag set
        det[2] = 1'b1;
        repeat (4) @(negedge clk);
        u_host.wr(`DSR_ADDR_ANALOG, 16'h0040);
        rchk(`DSR_ADDR_ANALOG, aw(8'h40));
        det[2] = 1'b0;
        repeat (4) @(negedge clk);
        u_host.wr(`DSR_ADDR_ANALOG, 16'h0040);
        rchk(`DSR_ADDR_ANALOG, aw(8'h00));
        for (int i = 0; i < 7; i++) begin
            lff = lfv[i];
            quiet = qv[i];
            rchk(`DSR_ADDR_STATUS, {1'b0, sv[i], 20'h0});
        end
        lff = 16'h0000;
        wdt = 1'b1;
        busy = 1'b1;
        mtag = 5'h1F;
        mres = 12'hABC;
        mval = 1'b1;
        @(negedge clk);
        mval = 1'b0;
        mtag = 5'h00;
        mres = 12'h000;
        rchk(`DSR_ADDR_STATUS, {4'b0001, 1'b1, 5'h1F, 12'hABC});
        wdt = 1'b0;
        busy = 1'b0;
        fault_pin = 1'b1;
        en[0] = 1'b0;
        det[0] = 1'b1;
        repeat (4) @(negedge clk);
        rchk(`DSR_ADDR_ANALOG, aw(8'h00));
        rchk(`DSR_ADDR_STATUS, {5'b10000, 5'h1F, 12'hABC});
        det[0] = 1'b0;
        en[0] = 1'b1;
        u_host.wr(`DSR_ADDR_STATUS, 16'hFFFF);
        chk("ro_write_attempt", 22'h1, {21'h0, ro_w});
        rchk(`DSR_ADDR_STATUS, {5'b10000, 5'h1F, 12'hABC});
        u_host.rd(5'h1F, d);
        chk("bad_address_access", 22'h1, {21'h0, bad});
        chk("rd_data", 22'h0, d);
        report_and_stop();
    end
endmodule
